// *** rtl/rad_core.sv ***
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module rad_core import rad_pkg::*; #(
	parameter int PMEM_DEPTH = RAD_PMEM_DEPTH,
	parameter int DMEM_DEPTH = RAD_DMEM_DEPTH,
	parameter int IPW        = $clog2(PMEM_DEPTH)
) (
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	input  wire logic                   ce,
	input  wire logic [3:0]             avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	input  wire logic [3:0]             avs_byteenable,
	output logic [31:0]                 avs_readdata,
	output logic                        avs_waitrequest,
	output logic [IPW-1:0]              prog_addr,
	input  wire logic [RAD_INSTR_W-1:0] prog_data,
	output logic [7:0]                  w_value
);

	// ****************************************************************
	// state
	// ****************************************************************
	logic [1:0]             phase;
	logic                   run;
	logic [RAD_INSTR_W-1:0] ir;
	logic                   ir_valid;
	logic [IPW-1:0]         ip;
	logic [7:0]             w;
	logic [2:0]             status;
	logic [7:0]             fsr;
	logic [15:0]            retired;
	logic                   bus_ack;
	logic [7:0]             dmem [DMEM_DEPTH];

	// ****************************************************************
	// decode
	// ****************************************************************
	rad_alu_op_t dec_op;
	logic        dec_lit;
	logic        dec_dest_w;
	logic        dec_wr;
	logic        dec_upd_c;
	logic        dec_upd_nib;
	logic        dec_upd_z;
	logic        dec_goto;

	// byte ops 00_oooo, bit ops 01_xx, goto 10_1, literals 11_xxxx
	always_comb begin
		dec_op      = RAD_ALU_PASSB;
		dec_lit     = 1'b0;
		dec_dest_w  = ~ir[7];
		dec_wr      = 1'b1;
		dec_upd_c   = 1'b0;
		dec_upd_nib = 1'b0;
		dec_upd_z   = 1'b0;
		dec_goto    = 1'b0;
		casez (ir[13:8])
			6'b00_0000: begin dec_op = RAD_ALU_PASSA; dec_wr = ir[7]; end // store w or no-op
			6'b00_0001: begin dec_op = RAD_ALU_CLR;   dec_upd_z = 1'b1; end
			6'b00_0010: begin
				dec_op = RAD_ALU_SUB; dec_upd_c = 1'b1; dec_upd_nib = 1'b1; dec_upd_z = 1'b1;
			end
			6'b00_0011: begin dec_op = RAD_ALU_DEC;   dec_upd_z = 1'b1; end
			6'b00_0100: begin dec_op = RAD_ALU_OR;    dec_upd_z = 1'b1; end
			6'b00_0101: begin dec_op = RAD_ALU_AND;   dec_upd_z = 1'b1; end
			6'b00_0110: begin dec_op = RAD_ALU_XOR;   dec_upd_z = 1'b1; end
			6'b00_0111: begin
				dec_op = RAD_ALU_ADD; dec_upd_c = 1'b1; dec_upd_nib = 1'b1; dec_upd_z = 1'b1;
			end
			6'b00_1000: begin dec_op = RAD_ALU_PASSB; dec_upd_z = 1'b1; end
			6'b00_1001: begin dec_op = RAD_ALU_COM;   dec_upd_z = 1'b1; end
			6'b00_1010: begin dec_op = RAD_ALU_INC;   dec_upd_z = 1'b1; end
			6'b00_1100: begin dec_op = RAD_ALU_RRC;   dec_upd_c = 1'b1; end
			6'b00_1101: begin dec_op = RAD_ALU_RLC;   dec_upd_c = 1'b1; end
			6'b00_1110: dec_op = RAD_ALU_SWAP;
			6'b01_00??: begin dec_op = RAD_ALU_BCLR;  dec_dest_w = 1'b0; end
			6'b01_01??: begin dec_op = RAD_ALU_BSET;  dec_dest_w = 1'b0; end
			6'b10_1???: begin dec_goto = 1'b1; dec_wr = 1'b0; end
			6'b11_00??: begin dec_lit = 1'b1; dec_dest_w = 1'b1; end
			6'b11_1000: begin
				dec_op = RAD_ALU_OR;  dec_lit = 1'b1; dec_dest_w = 1'b1; dec_upd_z = 1'b1;
			end
			6'b11_1001: begin
				dec_op = RAD_ALU_AND; dec_lit = 1'b1; dec_dest_w = 1'b1; dec_upd_z = 1'b1;
			end
			6'b11_1010: begin
				dec_op = RAD_ALU_XOR; dec_lit = 1'b1; dec_dest_w = 1'b1; dec_upd_z = 1'b1;
			end
			6'b11_110?, 6'b11_111?: begin                        // literal minus w, plus w
				dec_op      = ir[9] ? RAD_ALU_ADD : RAD_ALU_SUB;
				dec_lit     = 1'b1;
				dec_dest_w  = 1'b1;
				dec_upd_c   = 1'b1;
				dec_upd_nib = 1'b1;
				dec_upd_z   = 1'b1;
			end
			default: dec_wr = 1'b0; // skips, calls and returns belong to the control side
		endcase
	end

	// ****************************************************************
	// operand selection and ALU
	// ****************************************************************
	logic [6:0] faddr;
	logic [7:0] file_rd;
	logic [7:0] b_operand;
	logic [7:0] alu_res;
	logic       alu_c;
	logic       alu_nib;
	logic       alu_z;

	// the pointer register redirects the indirect slot; a loop back reads zero
	assign faddr     = (ir[6:0] == RAD_F_INDIRECT) ? fsr[6:0] : ir[6:0];
	// special registers share the file space, w does not appear in it
	assign file_rd   = (faddr == RAD_F_INDIRECT) ? 8'h00 :
	                   (faddr == RAD_F_IP_LO)    ? ip[7:0] :
	                   (faddr == RAD_F_STATUS)   ? {5'h00, status} :
	                   (faddr == RAD_F_POINTER)  ? fsr : dmem[faddr];
	// w is always operand a, the file or literal is operand b
	assign b_operand = dec_lit ? ir[7:0] : file_rd;

	rad_alu u_alu (
		.op         (dec_op), // two's complement add and subtract
		.a          (w),
		.b          (b_operand),
		.bit_sel    (ir[9:7]),
		.carry_in   (status[RAD_ST_CARRY]),
		.result     (alu_res),
		.carry_out  (alu_c),
		.nibble_out (alu_nib),
		.zero_out   (alu_z)
	);

	// ****************************************************************
	// execute strobes
	// ****************************************************************
	logic           exec;
	logic           act;
	logic           wr_file;
	logic           wr_w;
	logic           wr_ip;
	logic           redirect;
	logic [IPW-1:0] next_ip;
	logic [2:0]     st_written;
	logic [2:0]     next_status;

	// work happens once per four phases, on the last one
	assign exec      = ce & run & (phase == RAD_LAST_PHASE);
	assign act       = exec & ir_valid;
	assign wr_file   = act & dec_wr & ~dec_dest_w;
	assign wr_w      = act & dec_wr & dec_dest_w;
	assign wr_ip     = wr_file & (faddr == RAD_F_IP_LO);
	// goto or a write to the pointer low byte drops the prefetched word
	assign redirect  = act & (dec_goto | wr_ip);
	assign next_ip   = (act & dec_goto) ? IPW'(ir[10:0]) :
	                   wr_ip ? {ip[IPW-1:8], alu_res} : IPW'(ip + 1'b1);
	assign prog_addr = ip; // fetch runs beside the file access

	// flags from the ALU take priority over a direct write of the status byte
	assign st_written  = (wr_file & (faddr == RAD_F_STATUS)) ? alu_res[2:0] : status;
	assign next_status = {dec_upd_z   ? alu_z   : st_written[RAD_ST_ZERO],
	                      dec_upd_nib ? alu_nib : st_written[RAD_ST_NIBBLE],
	                      dec_upd_c   ? alu_c   : st_written[RAD_ST_CARRY]};

	// phase divider runs even while halted so the bus keeps a steady timebase
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) phase <= 2'h0;
		else if (ce)  phase <= phase + 2'h1;
	end

	// fetch stage: latch the word and step the pointer together
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ir       <= '0;
			ir_valid <= 1'b0;
			ip       <= '0;
		end else if (exec) begin
			ir       <= prog_data;
			ir_valid <= ~redirect;
			ip       <= next_ip;
		end
	end

	// execute stage registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			w       <= 8'h00;
			status  <= RAD_STATUS_RST;
			fsr     <= 8'h00;
			retired <= 16'h0000;
		end else begin
			if (wr_w) w <= alu_res;
			if (act) status <= next_status;
			if (wr_file && faddr == RAD_F_POINTER) fsr <= alu_res;
			if (act) retired <= retired + 16'h0001;
		end
	end

	// general purpose bytes; not reset, as in a plain RAM
	always_ff @(posedge clk) begin
		if (wr_file && faddr != RAD_F_IP_LO && faddr != RAD_F_STATUS &&
		    faddr != RAD_F_POINTER && faddr != RAD_F_INDIRECT)
			dmem[faddr] <= alu_res;
	end

	assign w_value = w;

	// ****************************************************************
	// Avalon-MM slave, one wait state on every access while ce stays high
	// ****************************************************************
	logic        bus_req;
	logic        bus_take;
	logic [31:0] rd_mux;

	assign bus_req         = avs_read | avs_write;
	// a frozen edge must not look like the completing one, so ce gates the release too
	assign avs_waitrequest = bus_req & ~bus_take;
	assign bus_take        = ce & bus_ack;
	assign rd_mux = (avs_address == RAD_REG_CTRL)    ? {31'h0, run} :
	                (avs_address == RAD_REG_STATE)   ? {16'(ip), 5'h00, status, w} :
	                (avs_address == RAD_REG_RETIRED) ? {16'h0000, retired} : 32'h0;

	// the ack also waits on ce, so a frozen block simply stretches the access
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_ack      <= 1'b0;
			run          <= RAD_RUN_RST;
			avs_readdata <= 32'h0;
		end else if (ce) begin
			bus_ack <= bus_req & ~bus_ack;
			if (avs_read & ~bus_ack) avs_readdata <= rd_mux;
			if (bus_take && avs_write && avs_address == RAD_REG_CTRL && avs_byteenable[0])
				run <= avs_writedata[RAD_CTRL_RUN];
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	logic [8:0] sub_ref;
	assign sub_ref = {1'b0, b_operand} + {1'b0, ~w} + 9'h001;

	phase_wrap_a: assert property (ce && phase == RAD_LAST_PHASE |=> phase == 2'h0)
		else $error("phase did not wrap after the fourth phase");
	ip_step_a: assert property (exec && !redirect |=> ip == IPW'($past(ip) + 1'b1))
		else $error("pointer did not step on a plain cycle");
	branch_flush_a: assert property (
		redirect |=> (!ir_valid && !exec)[*3] ##1 !ir_valid)
		else $error("prefetched word survived a flow change");
	instr_load_a: assert property (exec && !redirect |=> ir == $past(prog_data) && ir_valid)
		else $error("instruction register missed the fetched word");
	fetch_addr_a: assert property (
		act && wr_file && !redirect |=> prog_addr == IPW'($past(prog_addr) + 1'b1))
		else $error("fetch did not advance beside a file write");
	zero_flag_a: assert property (act && dec_upd_z |=> status[RAD_ST_ZERO] == ($past(alu_res) == 8'h00))
		else $error("zero flag disagrees with result");
	sub_borrow_a: assert property (act && dec_op == RAD_ALU_SUB |=> status[RAD_ST_CARRY] == $past(sub_ref[8]))
		else $error("subtract carry is not the inverted borrow");
	w_update_a: assert property (wr_w |=> w == $past(alu_res) && w_value == w)
		else $error("working register did not take the result");
	single_cycle_a: assert property (act && !redirect ##1 ce[*4] |-> ir_valid)
		else $error("plain instruction stalled the pipeline");
	bus_wait_a: assert property (
		$rose(bus_req) && ce |-> avs_waitrequest ##1 (avs_waitrequest == !ce))
		else $error("bus access did not finish after one wait state");
	// a low clock enable must leave the phase, ip and w where they were
	ce_freeze_a: assert property (
		!ce |=> $stable(phase) && $stable(ip) && $stable(w))
		else $error("state moved while the clock enable was low");
	rotate_carry_a: assert property (
		act && dec_op == RAD_ALU_RLC |=> status[RAD_ST_CARRY] == $past(b_operand[7]))
		else $error("rotate left did not move bit 7 into carry");

	// main scenarios: branch, borrow, indirect write, start by bus, pointer write
	branch_c: cover property (act && dec_goto ##[4:8] act);
	sub_c: cover property (act && dec_op == RAD_ALU_SUB && !alu_c);
	indirect_c: cover property (act && ir[6:0] == RAD_F_INDIRECT && wr_file);
	run_write_c: cover property (bus_take && avs_write ##[1:8] exec);
	ip_write_c: cover property (act && wr_ip);

endmodule : rad_core

// *** rtl/rad_pkg.sv ***
package rad_pkg;

	// ****************************************************************
	// widths and memory sizes
	// ****************************************************************
	localparam int RAD_INSTR_W     = 14;   // one program word holds a whole instruction
	localparam int RAD_DATA_W      = 8;
	localparam int RAD_PMEM_DEPTH  = 2048; // largest variant; 512 and 1024 also valid
	localparam int RAD_DMEM_DEPTH  = 128;  // 96 on the smaller variants
	localparam int RAD_FADDR_W     = 7;

	// ****************************************************************
	// timing: one instruction cycle is four clock phases
	// ****************************************************************
	localparam int         RAD_PHASES     = 4;
	localparam logic [1:0] RAD_LAST_PHASE = 2'h3;
	localparam int         RAD_CLK_NS     = 25;
	localparam int         RAD_ICYCLE_NS  = RAD_PHASES * RAD_CLK_NS;

	// ****************************************************************
	// special function registers in the file address space
	// ****************************************************************
	localparam logic [6:0] RAD_F_INDIRECT = 7'h00;
	localparam logic [6:0] RAD_F_IP_LO    = 7'h02;
	localparam logic [6:0] RAD_F_STATUS   = 7'h03;
	localparam logic [6:0] RAD_F_POINTER  = 7'h04;
	localparam int         RAD_ST_CARRY   = 0;
	localparam int         RAD_ST_NIBBLE  = 1;
	localparam int         RAD_ST_ZERO    = 2;
	localparam logic [2:0] RAD_STATUS_RST = 3'h0;

	// ****************************************************************
	// bus register map (byte addresses)
	// ****************************************************************
	localparam logic [3:0]  RAD_REG_CTRL    = 4'h0;
	localparam logic [3:0]  RAD_REG_STATE   = 4'h4;
	localparam logic [3:0]  RAD_REG_RETIRED = 4'h8;
	localparam int          RAD_CTRL_RUN    = 0;
	localparam logic        RAD_RUN_RST     = 1'b0;

	typedef enum logic [3:0] {
		RAD_ALU_ADD, RAD_ALU_SUB, RAD_ALU_AND, RAD_ALU_OR, RAD_ALU_XOR,
		RAD_ALU_PASSA, RAD_ALU_PASSB, RAD_ALU_COM, RAD_ALU_INC, RAD_ALU_DEC,
		RAD_ALU_RLC, RAD_ALU_RRC, RAD_ALU_SWAP, RAD_ALU_CLR, RAD_ALU_BCLR, RAD_ALU_BSET
	} rad_alu_op_t;

endpackage : rad_pkg

// *** rtl/rad_alu.sv ***
`timescale 1ns/10ps
module rad_alu import rad_pkg::*; (
	input  wire rad_alu_op_t  op,
	input  wire logic [7:0]   a,
	input  wire logic [7:0]   b,
	input  wire logic [2:0]   bit_sel,
	input  wire logic         carry_in,
	output logic [7:0]        result,
	output logic              carry_out,
	output logic              nibble_out,
	output logic              zero_out
);

	// ****************************************************************
	// shared adder
	// ****************************************************************
	logic [7:0] add_y;
	logic       add_c0;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] bit_mask;

	// subtract is b + ~a + 1, so carry high means no borrow
	assign add_y    = (op == RAD_ALU_SUB) ? ~a :
	                  (op == RAD_ALU_INC) ? 8'h00 :
	                  (op == RAD_ALU_DEC) ? 8'hff : a;
	assign add_c0   = (op == RAD_ALU_SUB) || (op == RAD_ALU_INC);
	assign sum      = {1'b0, b} + {1'b0, add_y} + {8'h00, add_c0};
	assign nib      = {1'b0, b[3:0]} + {1'b0, add_y[3:0]} + {4'h0, add_c0};
	assign bit_mask = 8'h01 << bit_sel;

	// result selection
	always_comb begin
		unique case (op)
			RAD_ALU_ADD, RAD_ALU_SUB,
			RAD_ALU_INC, RAD_ALU_DEC: result = sum[7:0];
			RAD_ALU_AND:   result = a & b;
			RAD_ALU_OR:    result = a | b;
			RAD_ALU_XOR:   result = a ^ b;
			RAD_ALU_PASSA: result = a;
			RAD_ALU_PASSB: result = b;
			RAD_ALU_COM:   result = ~b;
			RAD_ALU_RLC:   result = {b[6:0], carry_in};
			RAD_ALU_RRC:   result = {carry_in, b[7:1]};
			RAD_ALU_SWAP:  result = {b[3:0], b[7:4]};
			RAD_ALU_CLR:   result = 8'h00;
			RAD_ALU_BCLR:  result = b & ~bit_mask;
			RAD_ALU_BSET:  result = b | bit_mask;
		endcase
	end

	// flag values; the core decides which of them it keeps
	assign carry_out  = (op == RAD_ALU_RLC) ? b[7] : (op == RAD_ALU_RRC) ? b[0] : sum[8];
	assign nibble_out = nib[4];
	assign zero_out   = (result == 8'h00);

endmodule : rad_alu

// *** bench/rad_prog_rom.sv ***
`timescale 1ns/10ps
// ****************************************************************
// program memory on the core's fetch port
// ****************************************************************
module rad_prog_rom import rad_pkg::*; #(
	parameter int DEPTH = RAD_PMEM_DEPTH,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic [AW-1:0]          prog_addr,
	output logic      [RAD_INSTR_W-1:0] prog_data
);
	// filled by the bench while the core is halted; no latency, so the fetch never waits
	logic [RAD_INSTR_W-1:0] mem [DEPTH];

	// one whole word per address on a bus of its own, apart from data memory
	assign prog_data = mem[prog_addr];
endmodule : rad_prog_rom

// *** bench/risc_alu_datapath_bench.sv ***
`timescale 1ns/10ps
module risc_alu_datapath_bench import rad_pkg::*;;
	typedef struct {logic [31:0] exp; logic [31:0] mask; bit delta;} rad_note_t;
	logic        clk, reset_n, ce, avs_read, avs_write, avs_waitrequest;
	logic [3:0]  avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, prev_data;
	logic [10:0] prog_addr;
	logic [13:0] prog_data;
	logic [7:0]  w_value, a, b;
	logic [8:0]  s;
	int          error_cnt, total_checks, cyc;
	rad_note_t   notes [$];
	rad_note_t   n;

	// ****************************************************************
	// clock, design and program memory
	// ****************************************************************
	initial clk = 1'b0;
	always #12.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	rad_core i_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .prog_addr(prog_addr), .prog_data(prog_data),
		.w_value(w_value));
	rad_prog_rom i_rom (.prog_addr(prog_addr), .prog_data(prog_data));

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim;
		check(notes.size(), 32'h0);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim

	// one bus access; called just after a rising edge, returns just after one
	task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] d,
		input logic [3:0] be);
		avs_address <= ad;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= ~wr;
		// sampled at the rising edge, before that edge's flop updates land
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic rd(input logic [3:0] ad, input logic [31:0] m, input logic [31:0] e, bit dl);
		notes.push_back('{e, m, dl});
		bus(1'b0, ad, $urandom, 4'hf);
	endtask : rd

	// reset also refills program memory with load-literal filler words
	task automatic do_reset;
		reset_n <= 1'b0;
		foreach (i_rom.mem[k]) i_rom.mem[k] = 14'h3000;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
	endtask : do_reset

	// ip is left out of the compare: a goto-to-self loop flips it between two values
	task automatic run_prog(input logic [13:0] p [$], input logic [10:0] e);
		do_reset;
		foreach (p[k]) i_rom.mem[k] = p[k];
		bus(1'b1, RAD_REG_CTRL, 32'h1, 4'hf);
		repeat (40 + 8 * p.size()) @(posedge clk);
		rd(RAD_REG_STATE, 32'h7ff, {21'h0, e}, 0);
		check({24'h0, w_value}, {24'h0, e[7:0]});
	endtask : run_prog

	// retired count over span cycles, off of them with the clock enable low
	task automatic rate(input int span, input int off, input logic [31:0] e);
		int t0;
		t0 = cyc;
		rd(RAD_REG_RETIRED, 32'hffff0000, 32'h0, 0);
		if (off > 0) begin
			ce <= 1'b0;
			repeat (off) @(posedge clk);
			ce <= 1'b1;
		end
		while (cyc < t0 + span) @(posedge clk);
		rd(RAD_REG_RETIRED, 32'hffff, e, 1);
	endtask : rate

	// ****************************************************************
	// result watcher: oldest note against each read answer
	// ****************************************************************
	always @(posedge clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && notes.size() > 0) begin
			n = notes.pop_front();
			check((n.delta ? avs_readdata - prev_data : avs_readdata) & n.mask, n.exp);
			prev_data = avs_readdata;
		end
	end

	// a hang counts as a failure and closes the run the usual way
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_sim;
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{reset_n, ce, avs_read, avs_write} = 4'b0100;
		{avs_address, avs_byteenable, avs_writedata} = '0;
		{error_cnt, total_checks} = '0;
		void'($urandom(50));
		do_reset;
		// reset values, refused writes and the unmapped hole
		rd(RAD_REG_CTRL, 32'hffffffff, 32'h0, 0);
		rd(RAD_REG_STATE, 32'hffffffff, 32'h0, 0);
		rd(RAD_REG_RETIRED, 32'hffffffff, 32'h0, 0);
		bus(1'b1, RAD_REG_STATE, $urandom, 4'hf);
		bus(1'b1, 4'hc, $urandom, 4'hf);
		bus(1'b1, RAD_REG_CTRL, 32'h1, 4'h0);
		rd(4'hc, 32'hffffffff, 32'h0, 0);
		rd(RAD_REG_STATE, 32'hffffffff, 32'h0, 0);
		rd(RAD_REG_CTRL, 32'hffffffff, 32'h0, 0);
		// carries out of both bit 3 and bit 7 with a zero result
		run_prog('{14'h3088, 14'h3e78, 14'h2802}, 11'h700);
		// literal minus w, with and without borrow
		run_prog('{14'h3001, 14'h3c00, 14'h2802}, 11'h0ff);
		run_prog('{14'h3005, 14'h3c15, 14'h2802}, 11'h310);
		// logic literals setting and clearing zero
		run_prog('{14'h30f0, 14'h390f, 14'h383c, 14'h3a3c, 14'h2804}, 11'h400);
		// rotates, bit ops, inc, dec, complement, clear, add to file, pointer low write
		run_prog('{14'h3081, 14'h00a1, 14'h0da1, 14'h0ca1, 14'h14a1, 14'h13a1, 14'h0aa1,
			14'h03a1, 14'h0100, 14'h0921, 14'h07a1, 14'h0621, 14'h3010, 14'h0082,
			14'h01a1, 14'h01a1, 14'h0821, 14'h0d21, 14'h2812}, 11'h1fe);
		// goto skips a word; pointer then indirect swap then direct move
		run_prog('{14'h30a5, 14'h00a0, 14'h2804, 14'h30ee, 14'h3020, 14'h0084,
			14'h0e80, 14'h0820, 14'h2808}, 11'h05a);
		rate(80, 0, 32'ha);
		// straight-line code retires one word every four enabled clocks
		run_prog('{14'h3000}, 11'h000);
		rate(80, 16, 32'h10);
		// random add with a literal and subtract through a file register
		repeat (4) begin
			a = $urandom;
			b = $urandom;
			s = {1'b0, a} + {1'b0, b};
			run_prog('{14'h3000 | a, 14'h3e00 | b, 14'h2802},
				{s[7:0] == 8'h0, {1'b0, a[3:0]} + b[3:0] > 5'hf, s[8], s[7:0]});
			s = {1'b0, a} - {1'b0, b};
			run_prog('{14'h3000 | a, 14'h00b0, 14'h3000 | b, 14'h0230, 14'h2804},
				{s[7:0] == 8'h0, a[3:0] >= b[3:0], a >= b, s[7:0]});
		end
		end_sim;
	end
endmodule : risc_alu_datapath_bench
